/* File: tb/host_model.sv */
// host-side model driving the bank's register access port
`timescale 1ns/100ps
module host_model (
  input  wire       clk_in,
  output reg        wr_en_out = 1'b0,
  output reg  [7:0] addr_out  = 8'h00,
  output reg  [7:0] data_out  = 8'h00
);
  // one-edge strobe; data is made stale once the write is taken
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_in) #2 wr_en_out = 1'b1;
    addr_out = a;
    data_out = d;
    @(posedge clk_in) #2 wr_en_out = 1'b0;
    data_out = ~d;
  endtask
  task rd(input [7:0] a);
    @(posedge clk_in) #2 addr_out = a;
    @(posedge clk_in) #1;
  endtask
endmodule

/* File: tb/regbank_sva.sv */
// concurrent checks on the register bank ports
`timescale 1ns/100ps
module regbank_sva (
  input wire       clk_in,
  input wire       rst_in,
  input wire       clk_en_in,
  input wire       wr_en_in,
  input wire [7:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire [7:0] rd_data_out,
  input wire       output_on_out,
  input wire [5:0] voltage_code_out,
  input wire       discharge_enable_out,
  input wire [2:0] slew_code_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire       w_ctl = clk_en_in && wr_en_in && addr_in == 8'h02;
  wire [3:0] hi = wr_data_in[7:4];
  reset_vals_a: assert property ($fell(rst_in) |-> rd_data_out == 8'h00 &&
    discharge_enable_out && slew_code_out == 3'h0 && voltage_code_out == 6'h17)
    else $error("wrong values after reset");
  ctrl_rsvd_a: assert property ($past(clk_en_in) && $past(addr_in) == 8'h02 |->
    rd_data_out[3:0] == 4'h0) else $error("control reserved bits set");
  id1_rsvd_a: assert property ($past(clk_en_in) && $past(addr_in) == 8'h03 |->
    !rd_data_out[4]) else $error("id one reserved bit set");
  id2_rsvd_a: assert property ($past(clk_en_in) && $past(addr_in) == 8'h04 |->
    rd_data_out[7:4] == 4'h0) else $error("id two reserved bits set");
  status_read_a: assert property ($past(clk_en_in) && $past(addr_in) == 8'h05 |->
    rd_data_out[6:0] == 7'h00 && (!rd_data_out[7] || $past(output_on_out, 2)))
    else $error("bad status read");
  soft_reset_a: assert property (w_ctl && wr_data_in[2] |=> discharge_enable_out &&
    slew_code_out == 3'h0 && voltage_code_out == 6'h17) else $error("soft reset missed");
  ctrl_write_a: assert property (w_ctl && !wr_data_in[2] |=>
    {discharge_enable_out, slew_code_out} == $past(hi)) else $error("control write lost");
  bank_write_a: assert property (clk_en_in && wr_en_in && addr_in < 8'h02 ##1
    clk_en_in && !wr_en_in && $stable(addr_in) |=> rd_data_out == $past(wr_data_in, 2))
    else $error("bank readback wrong");
  freeze_hold_a: assert property (!clk_en_in |=> $stable(rd_data_out) &&
    $stable(discharge_enable_out) && $stable(slew_code_out) && $stable(voltage_code_out))
    else $error("state moved while clock enable low");
endmodule
bind regbank regbank_sva chk (.*);

/* File: tb/regbank_tb.sv */
// self-checking bench for the regulator register bank
`timescale 1ns/100ps
module regbank_tb;
  reg        clk_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1;
  reg        hw_enable_pin_in = 1'b0, bank_select_pin_in = 1'b0;
  wire       wr_en_in, output_on_out, light_load_forced_pwm_out, discharge_enable_out;
  wire [7:0] addr_in, wr_data_in, rd_data_out;
  wire [5:0] voltage_code_out;
  wire [2:0] slew_code_out;
  int        seed = 68836, num_errors = 0, total_checks = 0, i, a;
  reg  [7:0] r;
  always #25 clk_in = ~clk_in;
  host_model host (.clk_in(clk_in), .wr_en_out(wr_en_in), .addr_out(addr_in),
    .data_out(wr_data_in));
  regbank #(.SOFT_START_CYCLES(20)) dut (.*);
  function [7:0] dflt(input int a);
    case (a)
      0, 1: dflt = 8'h97;
      2: dflt = 8'h80;
      3: dflt = 8'hA3;
      4: dflt = 8'h02;
      default: dflt = 8'h00;
    endcase
  endfunction
  task chk(input [7:0] g, input [7:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %0t got %h want %h", $time, g, e);
    end
  endtask
  task rdchk(input int a, input [7:0] e);
    host.rd(a[7:0]);
    chk(rd_data_out, e);
  endtask
  task summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000000 num_errors++;
    summarize;
  end
  initial begin
    repeat (8) @(posedge clk_in);
    #2 rst_in = 1'b0;
    for (a = 0; a < 7; a++) rdchk(a, dflt(a));
    for (i = 0; i < 35; i++) begin
      a = i % 7;
      r = $random(seed);
      if (i < 7) r = 8'hFF;
      if (a == 2) r[2] = 1'b0;
      host.wr(a[7:0], r);
      rdchk(a, a < 2 ? r : a == 2 ? r & 8'hF0 : dflt(a));
      if (a == 2) chk({discharge_enable_out, slew_code_out}, r[7:4]);
    end
    for (i = 0; i < 8; i++) begin
      host.wr(8'h00, {i[2], 7'h40});
      host.wr(8'h01, {~i[2], 7'h3F});
      hw_enable_pin_in = i[0];
      bank_select_pin_in = i[1];
      repeat (6) @(posedge clk_in);
      chk({output_on_out, light_load_forced_pwm_out, voltage_code_out},
        {i[0] & (i[1] ? ~i[2] : i[2]), ~i[1], i[1] ? 6'h3F : 6'h00});
    end
    host.wr(8'h01, 8'h80);
    rdchk(5, 8'h00);
    repeat (24) @(posedge clk_in);
    rdchk(5, 8'h80);
    #1 hw_enable_pin_in = 1'b0;
    repeat (6) @(posedge clk_in);
    rdchk(5, 8'h00);
    host.wr(8'h02, 8'h7C);
    for (a = 0; a < 6; a++) rdchk(a, dflt(a));
    #1 rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #2 rst_in = 1'b0;
    rdchk(0, 8'h97);
    #1 clk_en_in = 1'b0;
    host.wr(8'h01, 8'h15);
    rdchk(1, 8'h97);
    #1 clk_en_in = 1'b1;
    rdchk(1, 8'h97);
    summarize;
  end
endmodule

/* File: verilog/regbank.v */
// register bank of an i2c-controlled step-down regulator
`timescale 1ns/100ps
// ==========================================================================
// Notes on behaviour
// - bank bit 7 is software enable, default 1; enable pin low forces output off
// - bank bit 6 selects light-load mode, default 0; 1 forces continuous pwm
// - bank bits 5:0 hold linear voltage code, 0.7125V plus 12.5mV per step
// - voltage code of both banks resets to 010111, meaning 1.0V
// - with enable pin high, select pin picks which bank's enable decides
// - control bit 7 enables output discharge, reset value 1
// - control bits 6:4 set rising slew interval, 0.15us doubling per code
// - reserved bits always read back as zero
// - writing 1 to control bit 2 returns both banks and the control register to defaults
// - first id register is read-only vendor and option codes
// - second id register is read-only mask revision code
// - status bit 7 is 1 once enabled and soft-start finished
`include "regbank_defs.vh"

module regbank #(
  parameter [2:0]  VENDOR_CODE        = 3'h5,   // arbitrary value
  parameter [3:0]  option_code        = 4'h3,   // arbitrary value
  parameter [3:0]  mask_revision_code = 4'h2,   // arbitrary value
  parameter [31:0] SOFT_START_CYCLES  = `SOFT_START_CYCLES
) (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       clk_en_in,
  input  wire       wr_en_in,
  input  wire [7:0] addr_in,
  input  wire [7:0] wr_data_in,
  output reg  [7:0] rd_data_out,
  input  wire       hw_enable_pin_in,
  input  wire       bank_select_pin_in,
  output wire       output_on_out,
  output wire       light_load_forced_pwm_out,
  output wire [5:0] voltage_code_out,
  output wire       discharge_enable_out,
  output wire [2:0] slew_code_out
);

  // ========================================================================
  // pin synchronisers: three stages per pin, change accepted when stages 2 and 3 agree
  // a lone disagreeing sample never matches the stage beside it and is dropped, so a late settle in
  // stage 2 never reaches the output steering
  // index 0 carries the enable pin, index 1 the bank select pin
  wire [1:0] pin_raw = {bank_select_pin_in, hw_enable_pin_in};
  wire [1:0] pin_seen;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : pin_sync
      reg [2:0] stage_q;
      reg       seen_q;

      always @(posedge clk_in) begin
        if (rst_in) begin
          stage_q <= 3'h0;
          seen_q  <= 1'h0;
        end else if (clk_en_in) begin
          stage_q <= {stage_q[1:0], pin_raw[g]};
          if (stage_q[1] == stage_q[2])
            seen_q <= stage_q[2];
        end
      end

      assign pin_seen[g] = seen_q;
    end
  endgenerate

  // filtered pin levels; both reset low, which matches the idle level of the pins
  wire en_pin  = pin_seen[0];
  wire sel_pin = pin_seen[1];

  // ========================================================================
  // registers
  // both banks keep their contents whichever one the select pin chooses,
  // so a host can preload the idle bank and switch voltage with the pin alone
  reg       sw_output_enable_bank_zero_q;
  reg       sw_output_enable_bank_one_q;
  reg       light_load_select_bank_zero_q;
  reg       light_load_select_bank_one_q;
  reg [5:0] voltage_code_bank_zero_q;
  reg [5:0] voltage_code_bank_one_q;
  reg       discharge_q;
  reg [2:0] slew_q;

  // write decode; a control write carrying the soft reset bit has no other effect,
  // and the bit itself is never stored, so it always reads back 0
  wire      wr_take    = clk_en_in && wr_en_in;
  wire      soft_reset = wr_take && (addr_in == `ADDR_CONTROL)
                         && wr_data_in[`CTRL_SRST_BIT];

  always @(posedge clk_in) begin
    if (rst_in || soft_reset) begin
      sw_output_enable_bank_zero_q  <= `BANK_EN_RESET;
      sw_output_enable_bank_one_q   <= `BANK_EN_RESET;
      light_load_select_bank_zero_q <= `BANK_MODE_RESET;
      light_load_select_bank_one_q  <= `BANK_MODE_RESET;
      voltage_code_bank_zero_q      <= `BANK_CODE_RESET;
      voltage_code_bank_one_q       <= `BANK_CODE_RESET;
      discharge_q                   <= `CTRL_DISCH_RESET;
      slew_q                        <= `CTRL_SLEW_RESET;
    end else if (wr_take) begin
      case (addr_in)
        `ADDR_BANK_ZERO: begin
          sw_output_enable_bank_zero_q  <= wr_data_in[`BANK_EN_BIT];
          light_load_select_bank_zero_q <= wr_data_in[`BANK_MODE_BIT];
          voltage_code_bank_zero_q      <= wr_data_in[`BANK_CODE_MSB:0];
        end
        `ADDR_BANK_ONE: begin
          sw_output_enable_bank_one_q   <= wr_data_in[`BANK_EN_BIT];
          light_load_select_bank_one_q  <= wr_data_in[`BANK_MODE_BIT];
          voltage_code_bank_one_q       <= wr_data_in[`BANK_CODE_MSB:0];
        end
        `ADDR_CONTROL: begin
          discharge_q <= wr_data_in[`CTRL_DISCH_BIT];
          slew_q      <= wr_data_in[`CTRL_SLEW_MSB:`CTRL_SLEW_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // output steering by enable pin and selected bank
  // the enable pin overrides both software enables; with it high the chosen
  // bank alone decides
  wire bank_enable = sel_pin ? sw_output_enable_bank_one_q
                             : sw_output_enable_bank_zero_q;
  assign output_on_out = en_pin && bank_enable;
  assign light_load_forced_pwm_out = sel_pin ? light_load_select_bank_one_q
                                             : light_load_select_bank_zero_q;
  assign voltage_code_out = sel_pin ? voltage_code_bank_one_q
                                    : voltage_code_bank_zero_q;
  assign discharge_enable_out = discharge_q;
  assign slew_code_out        = slew_q;

  // ========================================================================
  // soft-start timer and power-good flag
  // the timer restarts from zero whenever the output goes off, so a short
  // drop of the enable pin sampled low at two enabled edges in a row costs a full soft-start before power good
  // the counter stops once the flag is up, so it cannot wrap
  reg [31:0] ss_count_q;
  reg [31:0] ss_count_d;
  reg        power_good_flag_q;
  reg        power_good_flag_d;

  always @* begin
    ss_count_d        = ss_count_q;
    power_good_flag_d = power_good_flag_q;
    if (!output_on_out) begin
      ss_count_d        = 32'h0;
      power_good_flag_d = 1'h0;
    end else if (!power_good_flag_q) begin
      if (ss_count_q >= SOFT_START_CYCLES - 32'h1)
        power_good_flag_d = 1'h1;
      else
        ss_count_d = ss_count_q + 32'h1;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      ss_count_q        <= 32'h0;
      power_good_flag_q <= 1'h0;
    end else if (clk_en_in) begin
      ss_count_q        <= ss_count_d;
      power_good_flag_q <= power_good_flag_d;
    end
  end

  // ========================================================================
  // read data, reserved bits zero
  // the mux is combinational and the port registered, so a read shows the
  // address presented at the previous enabled edge; unmapped addresses read 0
  reg [7:0] rd_data_d;

  always @* begin
    rd_data_d = 8'h00;
    case (addr_in)
      `ADDR_BANK_ZERO: rd_data_d = {sw_output_enable_bank_zero_q,
                                    light_load_select_bank_zero_q,
                                    voltage_code_bank_zero_q};
      `ADDR_BANK_ONE:  rd_data_d = {sw_output_enable_bank_one_q,
                                    light_load_select_bank_one_q,
                                    voltage_code_bank_one_q};
      `ADDR_CONTROL:   rd_data_d = {discharge_q, slew_q, 4'h0};
      `ADDR_IDENT_ONE: rd_data_d = {VENDOR_CODE, 1'h0, option_code};
      `ADDR_IDENT_TWO: rd_data_d = {4'h0, mask_revision_code};
      `ADDR_STATUS:    rd_data_d = {power_good_flag_q, 7'h00};
      default:         rd_data_d = 8'h00;
    endcase
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (clk_en_in) begin
      rd_data_out <= rd_data_d;
    end
  end

endmodule

/* File: verilog/regbank_defs.vh */
// register map, field positions, reset values and timing counts of the regulator register bank
`ifndef REGBANK_DEFS_VH
`define REGBANK_DEFS_VH
`define ADDR_BANK_ZERO    8'h00
`define ADDR_BANK_ONE     8'h01
`define ADDR_CONTROL      8'h02
`define ADDR_IDENT_ONE    8'h03
`define ADDR_IDENT_TWO    8'h04
`define ADDR_STATUS       8'h05
`define BANK_EN_BIT       7
`define BANK_MODE_BIT     6
`define BANK_CODE_MSB     5
`define CTRL_DISCH_BIT    7
`define CTRL_SLEW_MSB     6
`define CTRL_SLEW_LSB     4
`define CTRL_SRST_BIT     2
`define STAT_POWER_GOOD_FLAG_BIT    7
`define BANK_EN_RESET     1'h1
`define BANK_MODE_RESET   1'h0
`define BANK_CODE_RESET   6'h17
`define CTRL_DISCH_RESET  1'h1
`define CTRL_SLEW_RESET   3'h0
`define SOFT_START_US     300
`define CLK_MHZ           20
`define SOFT_START_CYCLES (`SOFT_START_US * `CLK_MHZ)
`endif
